/* File: qread_map.svh */
// constants for the quad read / burst wrap command block
// assumes inclusion by the design modules
`ifndef QREAD_MAP_SVH
`define QREAD_MAP_SVH
`define CMD_QUAD_READ 8'hEB
`define CMD_WRAP_SETUP 8'h77
`define CMD_MODE_RESET 8'hFF
`define MODE_CONTINUE 2'h2
`define ADDR_NIBBLES 6'h06
`define MODE_NIBBLES 6'h02
`define LEGACY_DUMMY 6'h04
`define WRAP_IGNORED_NIBBLES 6'h06
`define WRAP_DATA_NIBBLES 6'h02
`define WRAP_RESET 3'h7
`define WRAP_DIS_BIT 0
`define WRAP_LEN_LSB 1
`define CMD_LAST_BIT 6'h07
`define MIN_LATENCY 4'h2
`define WRAP_MASK_8 24'h000007
`define WRAP_MASK_16 24'h00000F
`define WRAP_MASK_32 24'h00001F
`define WRAP_MASK_64 24'h00003F
`endif

/* File: qread_pkg.sv */
// types used by the quad read block; its edge finder does not use them
// assumes the map header sits in the same folder
`default_nettype none
package qread_pkg;
  typedef enum {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_WRAP_SKIP,
    ST_WRAP_BYTE,
    ST_IGNORE
  } phase_t;
endpackage
`default_nettype wire

/* File: pin_sync.sv */
// two-flop synchroniser for the serial pins, with serial clock edge strobes
// assumes pins_in comes from outside the CLOCK domain; srst is synchronous to clk
`default_nettype none
module pin_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] pins_in,
  output logic [5:0] pins_out,
  output logic sck_rise,
  output logic sck_fall
);
  typedef struct packed {
    logic [5:0] first;
    logic [5:0] second;
    logic sck_last;
  } sync_t;
  sync_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.first = pins_in;
    s_next.second = s_reg.first;
    s_next.sck_last = s_reg.second[0];
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign pins_out = s_reg.second;
  // bit 0 carries the serial clock
  assign sck_rise = s_reg.second[0] & ~s_reg.sck_last;
  assign sck_fall = ~s_reg.second[0] & s_reg.sck_last;
endmodule
`default_nettype wire

/* File: quad_io_read_burst_wrap.sv */
// quad address-and-data read with continuous mode and burst wrap, device end
// assumes serial clock well below CLOCK/4; memory array sits outside
`default_nettype none
`include "qread_map.svh"
module quad_io_read_burst_wrap (
  // system
  input wire logic CLOCK,
  input wire logic SRST,
  // serial link pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  // status register bits
  input wire logic QUAD_LINES_ENABLE_BIT,
  input wire logic VARIABLE_LATENCY_ENABLE,
  input wire logic [3:0] LATENCY_CONTROL,
  output logic [2:0] WRAP_SETTING_BITS,
  output logic CONTINUOUS_MODE_ACTIVE,
  // memory array
  output logic [23:0] MEM_ADDR,
  output logic MEM_REQ,
  input wire logic [7:0] MEM_DATA
);
  typedef struct packed {
    qread_pkg::phase_t phase;
    logic continuous;
    logic [2:0] wrap;
    logic [7:0] shift;
    logic [5:0] count;
    logic [23:0] addr;
    logic [7:0] mode;
    logic [7:0] out_byte;
    logic out_high;
    logic [3:0] io_out;
    logic oe;
    logic req;
  } state_t;
  state_t s_reg, s_next;
  logic [5:0] pins;
  logic sck_rise, sck_fall, cs_n_s;
  logic [3:0] io_s;
  logic [5:0] dummy_total;
  logic [23:0] addr_inc, wrap_mask;

  pin_sync u_sync (
    .clk(CLOCK),
    .srst(SRST),
    .pins_in({IO_IN, CS_N, SCK}),
    .pins_out(pins),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall)
  );
  assign cs_n_s = pins[1];
  assign io_s = pins[5:2];

  // latency field counts mode plus dummy cycles; mode always takes two
  always_comb begin
    if (VARIABLE_LATENCY_ENABLE && LATENCY_CONTROL > `MIN_LATENCY) begin
      dummy_total = {2'h0, LATENCY_CONTROL} - `MODE_NIBBLES;
    end else begin
      dummy_total = `LEGACY_DUMMY;
    end
  end

  // wrap section mask from the length select: 00=8, 01=16, 10=32, 11=64 bytes
  always_comb begin
    case (s_reg.wrap[2:1])
      2'h0: wrap_mask = `WRAP_MASK_8;
      2'h1: wrap_mask = `WRAP_MASK_16;
      2'h2: wrap_mask = `WRAP_MASK_32;
      default: wrap_mask = `WRAP_MASK_64;
    endcase
    if (s_reg.wrap[`WRAP_DIS_BIT]) begin
      addr_inc = s_reg.addr + 24'h000001;
    end else begin
      addr_inc = (s_reg.addr & ~wrap_mask) | ((s_reg.addr + 24'h000001) & wrap_mask);
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.req = 1'b0;
    if (cs_n_s) begin
      s_next.phase = qread_pkg::ST_IDLE;
      s_next.oe = 1'b0;
      s_next.count = '0;
    end else begin
      if (s_reg.phase == qread_pkg::ST_IDLE) begin
        s_next.count = '0;
        s_next.phase = s_reg.continuous ? qread_pkg::ST_ADDR : qread_pkg::ST_CMD;
      end
      if (sck_rise) begin
        case (s_reg.phase)
          qread_pkg::ST_IDLE, qread_pkg::ST_CMD: begin
            // command arrives one bit per clock on line 0
            s_next.shift = {s_reg.shift[6:0], io_s[0]};
            s_next.count = s_reg.count + 6'h01;
            s_next.phase = qread_pkg::ST_CMD;
            if (s_reg.count == `CMD_LAST_BIT) begin
              s_next.count = '0;
              if ({s_reg.shift[6:0], io_s[0]} == `CMD_QUAD_READ && QUAD_LINES_ENABLE_BIT) begin
                s_next.phase = qread_pkg::ST_ADDR;
              end else if ({s_reg.shift[6:0], io_s[0]} == `CMD_WRAP_SETUP &&
                           QUAD_LINES_ENABLE_BIT) begin
                s_next.phase = qread_pkg::ST_WRAP_SKIP;
              end else begin
                s_next.phase = qread_pkg::ST_IGNORE;
              end
            end
          end
          qread_pkg::ST_ADDR: begin
            s_next.addr = {s_reg.addr[19:0], io_s};
            s_next.count = s_reg.count + 6'h01;
            if (s_reg.count == `ADDR_NIBBLES - 6'h01) begin
              s_next.count = '0;
              s_next.phase = qread_pkg::ST_MODE;
            end
          end
          qread_pkg::ST_MODE: begin
            // low nibble is sampled but never used, the host may float it
            s_next.mode = {s_reg.mode[3:0], io_s};
            s_next.count = s_reg.count + 6'h01;
            if (s_reg.count == `MODE_NIBBLES - 6'h01) begin
              s_next.count = '0;
              s_next.phase = qread_pkg::ST_DUMMY;
              s_next.req = 1'b1;
              // an all-ones byte lands here and sets bit 4, leaving continuous mode
              s_next.continuous = (s_reg.mode[1:0] == `MODE_CONTINUE);
            end
          end
          qread_pkg::ST_DUMMY: begin
            s_next.count = s_reg.count + 6'h01;
            if (s_reg.count == dummy_total - 6'h01) begin
              s_next.count = '0;
              s_next.phase = qread_pkg::ST_DATA;
              s_next.out_byte = MEM_DATA;
              s_next.out_high = 1'b1;
            end
          end
          qread_pkg::ST_WRAP_SKIP: begin
            s_next.count = s_reg.count + 6'h01;
            if (s_reg.count == `WRAP_IGNORED_NIBBLES - 6'h01) begin
              s_next.count = '0;
              s_next.phase = qread_pkg::ST_WRAP_BYTE;
            end
          end
          qread_pkg::ST_WRAP_BYTE: begin
            s_next.shift = {s_reg.shift[3:0], io_s};
            s_next.count = s_reg.count + 6'h01;
            if (s_reg.count == `WRAP_DATA_NIBBLES - 6'h01) begin
              s_next.wrap = {s_reg.shift[2:0]};
              s_next.phase = qread_pkg::ST_IGNORE;
            end
          end
          default: begin
          end
        endcase
      end
      if (sck_fall && s_reg.phase == qread_pkg::ST_DATA) begin
        // device drives only from the first data falling edge on
        s_next.oe = 1'b1;
        s_next.io_out = s_reg.out_high ? s_reg.out_byte[7:4] : s_reg.out_byte[3:0];
        s_next.out_high = ~s_reg.out_high;
        if (!s_reg.out_high) begin
          s_next.addr = addr_inc;
          s_next.req = 1'b1;
        end
      end
      if (sck_rise && s_reg.phase == qread_pkg::ST_DATA && s_reg.out_high) begin
        s_next.out_byte = MEM_DATA;
      end
    end
    // an all-ones byte sent as a command also drops continuous mode; in continuous
    // mode the same byte arrives as address and mode nibbles and ends it there
    if (sck_rise && s_reg.phase == qread_pkg::ST_CMD && s_reg.count == `CMD_LAST_BIT &&
        {s_reg.shift[6:0], io_s[0]} == `CMD_MODE_RESET) begin
      s_next.continuous = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      s_reg <= '0;
      s_reg.phase <= qread_pkg::ST_IDLE;
      s_reg.wrap <= `WRAP_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign IO_OUT = s_reg.io_out;
  assign IO_OE = {4{s_reg.oe}};
  assign WRAP_SETTING_BITS = s_reg.wrap;
  assign CONTINUOUS_MODE_ACTIVE = s_reg.continuous;
  assign MEM_ADDR = s_reg.addr;
  assign MEM_REQ = s_reg.req;
endmodule
`default_nettype wire

/* File: qread_monitor.sv */
// checker for the quad read block, bound to its top module ports
// assumes one CLOCK domain and synchronous active high SRST
`default_nettype none
module qread_monitor (
  // system
  input wire logic CLOCK,
  input wire logic SRST,
  // link, status and memory request
  input wire logic CS_N,
  input wire logic QUAD_LINES_ENABLE_BIT,
  input wire logic [3:0] IO_OE,
  input wire logic [2:0] WRAP_SETTING_BITS,
  input wire logic CONTINUOUS_MODE_ACTIVE,
  input wire logic MEM_REQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  chk_wrap_reset_value: assert property ($past(SRST) |-> WRAP_SETTING_BITS == 3'h7)
    else $error("wrap bits not at power-up value");
  chk_oe_all_lanes: assert property (IO_OE == 4'h0 || IO_OE == 4'hF)
    else $error("io lanes not driven together");
  chk_oe_off_idle: assert property (CS_N [*6] |-> IO_OE == 4'h0)
    else $error("io driven while deselected");
  chk_wrap_idle: assert property (CS_N [*6] |=> $stable(WRAP_SETTING_BITS))
    else $error("wrap bits moved while deselected");
  chk_wrap_refused: assert property (!QUAD_LINES_ENABLE_BIT |=> $stable(WRAP_SETTING_BITS))
    else $error("wrap bits moved with quad lines off");
  chk_mode_idle: assert property (CS_N [*6] |=> $stable(CONTINUOUS_MODE_ACTIVE))
    else $error("continuous flag moved while deselected");
  chk_req_single: assert property (MEM_REQ |=> !MEM_REQ)
    else $error("memory request longer than one cycle");
  chk_oe_needs_cs: assert property ($rose(IO_OE[0]) |-> !CS_N)
    else $error("io drive began while deselected");
  chk_mode_needs_qe: assert property ($rose(CONTINUOUS_MODE_ACTIVE) |->
    QUAD_LINES_ENABLE_BIT && !CS_N)
    else $error("continuous flag set without quad read");
endmodule
bind quad_io_read_burst_wrap qread_monitor mon (.CLOCK(CLOCK), .SRST(SRST), .CS_N(CS_N),
  .QUAD_LINES_ENABLE_BIT(QUAD_LINES_ENABLE_BIT), .IO_OE(IO_OE),
  .WRAP_SETTING_BITS(WRAP_SETTING_BITS), .CONTINUOUS_MODE_ACTIVE(CONTINUOUS_MODE_ACTIVE),
  .MEM_REQ(MEM_REQ));
`default_nettype wire

/* File: spi_host_model.sv */
// host controller model: chip select, mode 0 serial clock, four io lines
// assumes CLOCK is the bench clock; each SCK half lasts four CLOCK periods
`default_nettype none
module spi_host_model (
  // bench clock
  input wire logic CLOCK,
  // link
  output logic CS_N,
  output logic SCK,
  output logic [3:0] IO_IN,
  input wire logic [3:0] IO_OUT,
  // collected byte
  output logic [7:0] rx,
  output logic rx_v
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    CS_N = 1'b1;
    SCK = 1'b0;
    IO_IN = 4'h0;
    rx = 8'h00;
    rx_v = 1'b0;
  end
  task automatic start();
    CS_N = 1'b0;
  endtask
  task automatic tick(input logic [3:0] n);
    IO_IN = n;
    repeat (4) @(negedge CLOCK);
    SCK = 1'b1;
    repeat (4) @(negedge CLOCK);
    SCK = 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    for (int i = 7; i >= 0; i--) tick({3'h5, c[i]});
  endtask
  // lines not driven by us toggle, so a stale value can never pass as data
  task automatic addr_mode(input logic [23:0] a, input logic [7:0] m, input int dummies);
    for (int i = 5; i >= 0; i--) tick(a[i*4 +: 4]);
    tick(m[7:4]);
    tick(~m[7:4]);
    for (int i = 0; i < dummies; i++) tick(~IO_IN);
  endtask
  task automatic rd();
    for (int i = 1; i >= 0; i--) begin
      IO_IN = ~IO_IN;
      repeat (4) @(negedge CLOCK);
      rx[i*4 +: 4] = IO_OUT;
      SCK = 1'b1;
      repeat (4) @(negedge CLOCK);
      SCK = 1'b0;
    end
    rx_v = 1'b1;
    @(negedge CLOCK);
    rx_v = 1'b0;
  endtask
  task automatic done();
    repeat (4) @(negedge CLOCK);
    CS_N = 1'b1;
    repeat (8) @(negedge CLOCK);
  endtask
endmodule
`default_nettype wire

/* File: quad_io_read_burst_wrap_test.sv */
// self-checking bench for the quad read block driven by the host model
// assumes design, checker and host model are compiled before it
`default_nettype none
module quad_io_read_burst_wrap_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic qe = 1'b0;
  logic vle = 1'b0;
  logic [3:0] lat = 4'h0;
  logic cs_n, sck, req, rx_v, cont;
  logic [3:0] io_in, io_out, io_oe;
  logic [2:0] wrap;
  logic [23:0] mem_addr, a;
  logic [7:0] rx;
  logic [7:0] exp_b;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int n_compared = 0;
  int seed = 28;
  `define CHECK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin miscompares++; \
    $display("BAD %s expected %h seen %h", nm, e, s); end end
  function automatic logic [7:0] mv(input logic [23:0] x);
    return x[7:0] ^ x[15:8];
  endfunction
  always #25 clock = ~clock;
  quad_io_read_burst_wrap dut (.CLOCK(clock), .SRST(srst), .CS_N(cs_n), .SCK(sck),
    .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_LINES_ENABLE_BIT(qe),
    .VARIABLE_LATENCY_ENABLE(vle), .LATENCY_CONTROL(lat), .WRAP_SETTING_BITS(wrap),
    .CONTINUOUS_MODE_ACTIVE(cont), .MEM_ADDR(mem_addr), .MEM_REQ(req),
    .MEM_DATA(mv(mem_addr)));
  spi_host_model hm (.CLOCK(clock), .CS_N(cs_n), .SCK(sck), .IO_IN(io_in),
    .IO_OUT(io_out), .rx(rx), .rx_v(rx_v));
  task automatic report_and_stop();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic reads(input int n, input logic [23:0] mask);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mv((a & ~mask) | ((a + 24'(i)) & mask)));
      hm.rd();
    end
    hm.done();
  endtask
  // the oldest note is taken once, so a mismatch print cannot pop a second one
  always @(posedge rx_v) begin
    exp_b = exp_q.pop_front();
    `CHECK("read byte", exp_b, rx)
    `CHECK("drive enable", 4'hF, io_oe)
  end
  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    `CHECK("wrap reset", 3'h7, wrap)
    hm.start(); hm.cmd(8'h77); hm.addr_mode(24'h0, 8'h00, 0); hm.done();
    `CHECK("wrap refused", 3'h7, wrap)
    qe = 1'b1;
    hm.start(); hm.cmd(8'h77); hm.addr_mode(24'h0, 8'hA0, 0); hm.done();
    `CHECK("wrap set", 3'h2, wrap)
    a = 24'h12341E;
    hm.start(); hm.cmd(8'hEB); hm.addr_mode(a, 8'hA5, 4);
    reads(4, 24'h00000F);
    `CHECK("mode kept", 1'b1, cont)
    a = 24'($random(seed));
    hm.start(); hm.addr_mode(a, 8'hFF, 4);
    reads(2, 24'h00000F);
    `CHECK("mode ended", 1'b0, cont)
    hm.start(); hm.cmd(8'h77); hm.addr_mode(a, 8'h10, 0); hm.done();
    `CHECK("wrap off", 3'h1, wrap)
    vle = 1'b1;
    // latency field counts mode plus dummies, two of them mode
    lat = 4'h6 + (4'($random(seed)) & 4'h3);
    a = 24'h00FFFF;
    hm.start(); hm.cmd(8'hEB); hm.addr_mode(a, 8'h20, int'(lat) - 2);
    reads(3, 24'hFFFFFF);
    `CHECK("mode set", 1'b1, cont)
    hm.start(); repeat (8) hm.tick(4'hF); hm.done();
    `CHECK("mode reset", 1'b0, cont)
    hm.start(); hm.cmd(8'h77); hm.addr_mode(a, 8'h40, 0); hm.done();
    `CHECK("wrap on", 3'h4, wrap)
    a = 24'h00803E;
    hm.start(); hm.cmd(8'hEB); hm.addr_mode(a, 8'h20, int'(lat) - 2);
    reads(3, 24'h00001F);
    // mid-run reset while wrap is on and continuous mode is set
    srst = 1'b1;
    repeat (3) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    `CHECK("wrap after reset", 3'h7, wrap)
    `CHECK("mode after reset", 1'b0, cont)
    hm.start(); hm.cmd(8'h77); hm.addr_mode(a, 8'h30, 0); hm.done();
    `CHECK("wrap recovered", 3'h3, wrap)
    report_and_stop();
  end
endmodule
`default_nettype wire
